// File: logic/notify_combine.sv
/*
  Gates fault levels with their enable bits and ORs them to one level.
  Assumes fault and enable vectors of equal width and order.
*/
`timescale 1ns/100ps
module notify_combine #(
  parameter int N = 10
) (
  input wire logic [N-1:0] fault,
  input wire logic [N-1:0] enable,
  output logic level
);

  // ****************************************************************
  // AND-OR reduction
  // ****************************************************************
  assign level = |(fault & enable);

endmodule : notify_combine

// File: logic/notify_pkg.sv
/*
  Constants shared by the standard event notification block.
  Assumes a 32-bit APB master and per-event fault levels from the detectors.
*/
package notify_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int EVENT_COUNT = 10;
  localparam int MASK_W = 16;
  localparam int EVENT_LSB = 6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int DIO_PINS_DEFAULT = 2;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [ADDR_W-1:0] MASK_IDX = 12'h08E;
  localparam logic [ADDR_W-1:0] ROLE_IDX = 12'h0C0;
  localparam logic [ADDR_W-1:0] INT_STAT_IDX = 12'h0C1;
  localparam logic [ADDR_W-1:0] INT_MASK_IDX = 12'h0C2;
  localparam logic [ADDR_W-1:0] FAULT_IDX = 12'h0C3;
  localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ROLE_ADDR = {ROLE_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] INT_STAT_ADDR = {INT_STAT_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = {INT_MASK_IDX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] FAULT_ADDR = {FAULT_IDX[ADDR_W-3:0], 2'b00};

  // ****************************************************************
  // Enable bit positions in the mask register
  // ****************************************************************
  localparam int CURRENT_HIGH_FAULT_BIT = 15;
  localparam int VOLTAGE_HIGH_FAULT_BIT = 14;
  localparam int POWER_HIGH_FAULT_BIT = 13;
  localparam int VOLTAGE_LOW_FAULT_BIT = 12;
  localparam int FREQUENCY_HIGH_FAULT_BIT = 11;
  localparam int FREQUENCY_LOW_FAULT_BIT = 10;
  localparam int TEMPERATURE_HIGH_FAULT_BIT = 9;
  localparam int TEMPERATURE_LOW_FAULT_BIT = 8;
  localparam int VOLTAGE_DIP_FAULT_BIT = 7;
  localparam int VOLTAGE_SPIKE_FAULT_BIT = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [MASK_W-1:0] MASK_RESET = 16'h0000;
  localparam logic [EVENT_COUNT-1:0] EVENT_RESET = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

endpackage : notify_pkg

// File: logic/std_event_notify.sv
/*
  Standard event notification mask with APB register access and interrupt.
  Assumes APB signals and fault levels synchronous to clk.
*/
// The APB register port is this design's own decision.
// Functional notes
// - Sixteen-bit mask register at index 0x008E, read/write, zero after reset.
// - Mask contents decide which faults may move the standard notification pin.
// - Only pins given the standard role by the role setting are affected.
// - Any mix of enables may be set; each acts on its own.
// - Enabled fault drives pin high; bits 15 to 6 order the ten events.
// - Disabled fault leaves the pin untouched.
`timescale 1ns/100ps
module std_event_notify #(
  parameter int DIO_PINS = notify_pkg::DIO_PINS_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [notify_pkg::ADDR_W-1:0] paddr,
  input wire logic [notify_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [notify_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic current_high_fault,
  input wire logic voltage_high_fault,
  input wire logic power_high_fault,
  input wire logic voltage_low_fault,
  input wire logic frequency_high_fault,
  input wire logic frequency_low_fault,
  input wire logic temperature_high_fault,
  input wire logic temperature_low_fault,
  input wire logic voltage_dip_fault,
  input wire logic voltage_spike_fault,
  output logic [DIO_PINS-1:0] dio_std_out,
  output logic [DIO_PINS-1:0] dio_std_oe,
  output logic irq
);

  localparam int EC = notify_pkg::EVENT_COUNT;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  generate
    if (DIO_PINS < 1 || DIO_PINS > 16) begin : g_bad_pins
      $error("DIO_PINS must lie between 1 and 16");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [EC-1:0] enable;
    logic [DIO_PINS-1:0] role;
    logic [EC-1:0] int_stat;
    logic [EC-1:0] int_mask;
    logic [EC-1:0] fault_prev;
    logic [DIO_PINS-1:0] pin;
    logic [notify_pkg::DATA_W-1:0] rdata;
    logic err;
  } state_t;

  localparam state_t STATE_RESET = '{
    enable: notify_pkg::MASK_RESET[notify_pkg::MASK_W-1:notify_pkg::EVENT_LSB],
    role: '0,
    int_stat: notify_pkg::EVENT_RESET,
    int_mask: notify_pkg::EVENT_RESET,
    fault_prev: notify_pkg::EVENT_RESET,
    pin: '0,
    rdata: notify_pkg::DATA_RESET,
    err: 1'b0
  };

  state_t st_reg;
  state_t st_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lane_write(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] strb
  );
    logic [15:0] res;
    res[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
    res[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
    return res;
  endfunction : lane_write

  function automatic logic addr_mapped(input logic [notify_pkg::ADDR_W-1:0] a);
    return a == notify_pkg::MASK_ADDR || a == notify_pkg::ROLE_ADDR ||
           a == notify_pkg::INT_STAT_ADDR || a == notify_pkg::INT_MASK_ADDR ||
           a == notify_pkg::FAULT_ADDR;
  endfunction : addr_mapped

  // ****************************************************************
  // Fault vector, bit 9 is mask bit 15
  // ****************************************************************
  logic [EC-1:0] faults;
  logic level;
  logic [EC-1:0] ev_active;
  logic [EC-1:0] new_evt;
  logic setup;
  logic wr_access;
  logic [15:0] wdata16;
  logic [15:0] mask_word;

  assign faults = {current_high_fault, voltage_high_fault, power_high_fault,
                   voltage_low_fault, frequency_high_fault, frequency_low_fault,
                   temperature_high_fault, temperature_low_fault,
                   voltage_dip_fault, voltage_spike_fault};
  assign ev_active = faults & st_reg.enable;
  assign new_evt = faults & ~st_reg.fault_prev;
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && pready && addr_mapped(paddr);
  assign wdata16 = pwdata[15:0];
  assign mask_word = {st_reg.enable, 6'h00};

  notify_combine #(
    .N(EC)
  ) u_combine (
    .fault(faults),
    .enable(st_reg.enable),
    .level(level)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [15:0] mw;
    mw = 16'h0000;
    st_next = st_reg;
    st_next.fault_prev = faults;
    if (setup) begin
      st_next.err = !addr_mapped(paddr);
      case (paddr)
        notify_pkg::MASK_ADDR: st_next.rdata = {16'h0000, mask_word};
        notify_pkg::ROLE_ADDR: st_next.rdata = 32'(st_reg.role);
        notify_pkg::INT_STAT_ADDR: st_next.rdata = 32'(st_reg.int_stat);
        notify_pkg::INT_MASK_ADDR: st_next.rdata = 32'(st_reg.int_mask);
        notify_pkg::FAULT_ADDR: st_next.rdata = 32'(faults);
        default: st_next.rdata = notify_pkg::DATA_RESET;
      endcase
    end else if (!(psel && penable)) begin
      st_next.err = 1'b0;
    end
    if (wr_access) begin
      case (paddr)
        notify_pkg::MASK_ADDR: begin
          mw = lane_write(mask_word, wdata16, pstrb[1:0]);
          st_next.enable = mw[notify_pkg::MASK_W-1:notify_pkg::EVENT_LSB];
        end
        notify_pkg::ROLE_ADDR: begin
          mw = lane_write(16'(st_reg.role), wdata16, pstrb[1:0]);
          st_next.role = mw[DIO_PINS-1:0];
        end
        notify_pkg::INT_STAT_ADDR: begin
          mw = lane_write(16'h0000, wdata16, pstrb[1:0]);
          st_next.int_stat = st_reg.int_stat & ~mw[EC-1:0];
        end
        notify_pkg::INT_MASK_ADDR: begin
          mw = lane_write(16'(st_reg.int_mask), wdata16, pstrb[1:0]);
          st_next.int_mask = mw[EC-1:0];
        end
        default: begin
          mw = 16'h0000;
        end
      endcase
    end
    // New events set status after any clear
    st_next.int_stat = st_next.int_stat | new_evt;
    // Pin uses the new role so a dropped pin never stays high
    st_next.pin = level ? st_next.role : '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.err && psel && penable;
  assign dio_std_out = st_reg.pin;
  assign dio_std_oe = st_reg.role;
  assign irq = |(st_reg.int_stat & st_reg.int_mask);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [15:0] exp_mask;
  assign exp_mask = lane_write(mask_word, wdata16, pstrb[1:0]);

  sequence s_mask_setup_read;
    psel && !penable && !pwrite && paddr == notify_pkg::MASK_ADDR;
  endsequence

  sequence s_mask_access_write;
    psel && penable && pwrite && paddr == notify_pkg::MASK_ADDR;
  endsequence

  property p_mask_write;
    s_mask_access_write |=> st_reg.enable == $past(exp_mask[15:6]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Mask write not stored");

  property p_mask_read;
    s_mask_setup_read ##1 (psel && penable) |->
      prdata[15:6] == $past(st_reg.enable) && prdata[31:16] == 16'h0000;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("Mask read returned wrong value");

  property p_mask_low_zero;
    s_mask_setup_read |=> prdata[5:0] == 6'h00;
  endproperty
  a_mask_low_zero: assert property (p_mask_low_zero)
    else $error("Unimplemented mask bits read nonzero");

  property p_pin_on;
    (|ev_active) |=> dio_std_out == dio_std_oe;
  endproperty
  a_pin_on: assert property (p_pin_on)
    else $error("Enabled fault did not drive pin");

  property p_pin_off;
    !(|ev_active) |=> dio_std_out == '0;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("Disabled fault moved pin");

  property p_pin_role;
    (dio_std_out & ~dio_std_oe) == '0;
  endproperty
  a_pin_role: assert property (p_pin_role)
    else $error("Unassigned pin driven high");

  property p_multi;
    $countones(ev_active) >= 2 ##1 $countones(ev_active) >= 1 |=>
      dio_std_out == dio_std_oe;
  endproperty
  a_multi: assert property (p_multi)
    else $error("Combined enables lost activity");

  property p_mask_gate;
    $changed(dio_std_out) |->
      $past(ev_active) != $past(ev_active, 2) || st_reg.role != $past(st_reg.role);
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("Pin changed without gated cause");

  property p_or_level;
    ##1 dio_std_out == ($past(|(faults & st_reg.enable)) ? dio_std_oe : '0);
  endproperty
  a_or_level: assert property (p_or_level)
    else $error("Pin is not OR of gated faults");

  property p_event_sticky;
    (new_evt != '0) |=> (st_reg.int_stat & $past(new_evt)) == $past(new_evt);
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("Event did not set status");

  sequence s_stat_clear;
    psel && penable && pwrite && pstrb[1:0] == 2'b11 && paddr == notify_pkg::INT_STAT_ADDR;
  endsequence

  property p_stat_clear;
    s_stat_clear |=> (st_reg.int_stat & $past(pwdata[EC-1:0] & ~new_evt)) == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("Status bit not cleared by write");

  property p_irq_raise;
    (new_evt & st_reg.int_mask) != '0 && !(psel && penable && pwrite &&
      paddr == notify_pkg::INT_MASK_ADDR) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Unmasked event did not raise irq");

  property p_unmapped_read;
    psel && !penable && !addr_mapped(paddr) ##1 psel && penable |->
      pslverr && prdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped access not refused");

  property p_unmapped_write;
    psel && penable && pwrite && !addr_mapped(paddr) |=>
      $stable(st_reg.enable) && $stable(st_reg.role) && $stable(st_reg.int_mask);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("Unmapped write changed a register");

  property p_role_write;
    psel && penable && pwrite && pstrb[1:0] == 2'b11 && paddr == notify_pkg::ROLE_ADDR |=>
      dio_std_oe == $past(pwdata[DIO_PINS-1:0]);
  endproperty
  a_role_write: assert property (p_role_write)
    else $error("Role write not applied to pin enables");

endmodule : std_event_notify

// File: sim/notify_host.sv
/*
  Host side model that watches the notification pins.
  Assumes a pull-down on every pin, so a released pin reads low.
*/
`timescale 1ns/100ps
module notify_host #(
  parameter int N = 2
) (
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_level
);
  // ****************************************************************
  // Pin level as the host sees it
  // ****************************************************************
  assign pin_level = pin_out & pin_oe;
endmodule : notify_host

// File: sim/test_std_event_notify.sv
/*
  Self-checking bench for the standard event notification block.
  Assumes the design package is compiled first and a 40 MHz clock.
*/
`timescale 1ns/100ps
module test_std_event_notify;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] flt;
  logic [1:0] dout, doe, lvl;
  int error_cnt, n_checks, cyc;

  // ****************************************************************
  // Design, host model and clock
  // ****************************************************************
  std_event_notify #(.DIO_PINS(2)) std_event_notify_i (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_high_fault(flt[9]), .voltage_high_fault(flt[8]), .power_high_fault(flt[7]),
    .voltage_low_fault(flt[6]), .frequency_high_fault(flt[5]), .frequency_low_fault(flt[4]),
    .temperature_high_fault(flt[3]), .temperature_low_fault(flt[2]),
    .voltage_dip_fault(flt[1]), .voltage_spike_fault(flt[0]),
    .dio_std_out(dout), .dio_std_oe(doe), .irq(irq));
  notify_host #(.N(2)) notify_host_i (.pin_out(dout), .pin_oe(doe), .pin_level(lvl));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    chk("slverr", {31'h0, (a == 12'h010)}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_pin(input logic [9:0] f, input logic [15:0] m, input logic exp);
    apb(1'b1, notify_pkg::MASK_ADDR, {16'h0, m});
    @(posedge clk);
    flt <= f;
    repeat (3) @(posedge clk);
    #1;
    chk("pin0", {31'h0, exp}, {31'h0, lvl[0]});
    chk("pin1", 32'h0, {31'h0, lvl[1]});
    @(posedge clk);
    flt <= 10'h000;
  endtask : t_pin

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    apb(1'b0, notify_pkg::MASK_ADDR, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b1, notify_pkg::MASK_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, notify_pkg::MASK_ADDR, 32'h0);
    chk("mask ones", 32'h0000_FFC0, rd);
    apb(1'b1, notify_pkg::MASK_ADDR, 32'h0000_A57F);
    apb(1'b0, notify_pkg::MASK_ADDR, 32'h0);
    chk("mask mix", 32'h0000_A540, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs

  task automatic t_events();
    apb(1'b1, notify_pkg::ROLE_ADDR, 32'h1);
    apb(1'b0, notify_pkg::ROLE_ADDR, 32'h0);
    chk("role", 32'h1, rd);
    chk("oe", 32'h1, {30'h0, doe});
    for (int i = 0; i < 10; i++) begin
      t_pin(10'h001 << i, 16'h0040 << i, 1'b1);
      t_pin(10'h001 << i, 16'hFFC0 ^ (16'h0040 << i), 1'b0);
    end
    t_pin(10'h201, 16'h8040, 1'b1);
    t_pin(10'h201, 16'h7F80, 1'b0);
    t_pin(10'h3FF, 16'h0000, 1'b0);
    apb(1'b1, notify_pkg::ROLE_ADDR, 32'h0);
    t_pin(10'h200, 16'h8000, 1'b0);
  endtask : t_events

  task automatic t_irq();
    apb(1'b1, notify_pkg::INT_STAT_ADDR, 32'h3FF);
    apb(1'b1, notify_pkg::INT_MASK_ADDR, 32'h200);
    t_pin(10'h001, 16'h0, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, notify_pkg::INT_STAT_ADDR, 32'h0);
    chk("int_stat", 32'h1, rd);
    @(posedge clk);
    flt <= 10'h200;
    repeat (3) @(posedge clk);
    #1;
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, notify_pkg::INT_STAT_ADDR, 32'h201);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge clk);
    flt <= 10'h000;
  endtask : t_irq

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    flt = 10'h000;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("irq reset", 32'h0, {31'h0, irq});
    chk("oe reset", 32'h0, {30'h0, doe});
    t_regs();
    t_events();
    t_irq();
    finish_test();
  end
endmodule : test_std_event_notify
